// ### bench/pcio_assertions.sv
// Port checker for the preset counter input and output control block.
`timescale 1ns/1ps
module pcio_assertions
   import pcio_pkg::*;
#(
   parameter int unsigned WIDTH = CNT_W
) (
   // Clock and reset.
   input wire logic       clock_in,
   input wire logic       srst_in,
   // Pins.
   input wire logic       reset_one_in,
   input wire logic       reset_indicator_out,
   input wire logic       key_lock_out,
   input wire logic [5:0] keys_out,
   // Bus handshakes.
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready
);
   default clocking dc @(posedge clock_in); endclocking
   default disable iff (srst_in);
   property p_rst_on;
      $rose(reset_one_in) && !reset_indicator_out |=>
         !reset_indicator_out ##[1:3] reset_indicator_out;
   endproperty
   a_rst_on: assert property (p_rst_on) else $error("Indicator timing wrong");
   property p_rst_off;
      !reset_one_in [*5] |-> !reset_indicator_out;
   endproperty
   a_rst_off: assert property (p_rst_off) else $error("Indicator lit");
   property p_key;
      key_lock_out |-> keys_out == 6'h00;
   endproperty
   a_key: assert property (p_key) else $error("Keys pass while locked");
   property p_wr_resp;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("Write response late");
   property p_rd_resp;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("Read response late");
   property p_busy;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_busy: assert property (p_busy) else $error("Ready while response pending");
   property p_wr_done;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
   endproperty
   a_wr_done: assert property (p_wr_done) else $error("Write response not released");
   property p_rd_done;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
   endproperty
   a_rd_done: assert property (p_rd_done) else $error("Read response not released");
endmodule
bind pcio_top pcio_assertions #(.WIDTH(WIDTH)) u_chk (
   .clock_in, .srst_in, .reset_one_in, .reset_indicator_out, .key_lock_out, .keys_out,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready
);

// ### bench/pcio_field.sv
// Model of the sensors, contacts and loads wired to the block.
`timescale 1ns/1ps
module pcio_field (
   // Clock.
   input  wire logic clock_in,
   // Lines toward the block.
   output logic      count_a_out = 1'b0,
   output logic      count_b_out = 1'b0,
   output logic      reset_one_out = 1'b0,
   output logic      reset_two_out = 1'b0,
   output logic      key_short_out = 1'b0,
   // Loads.
   input  wire logic load_one_in,
   input  wire logic load_two_in
);
   // Each edge is held long enough to pass the synchroniser.
   task automatic pulse(input logic on_b, input int n);
      repeat (n) begin
         @(posedge clock_in);
         {count_b_out, count_a_out} <= on_b ? 2'b10 : 2'b01;
         repeat (3) @(posedge clock_in);
         {count_b_out, count_a_out} <= 2'b00;
         repeat (6) @(posedge clock_in);
      end
   endtask
   task automatic lines(input logic r1, input logic r2, input logic k);
      @(posedge clock_in);
      reset_one_out <= r1;
      reset_two_out <= r2;
      key_short_out <= k;
   endtask
endmodule

// ### bench/preset_counter_io_control_tb.sv
// Self-checking bench for the preset counter input and output control block.
`timescale 1ns/1ps
module preset_counter_io_control_tb
   import pcio_pkg::*;
;
   logic        clock_in = 1'b0;
   logic        srst_in = 1'b1;
   logic        tacho_sample_in = 1'b0;
   logic [5:0]  keys_raw_in = 6'h00;
   logic        count_input_a_in, count_input_b_in, reset_one_in, reset_two_in, key_short_in;
   logic        output_stage_one_out, output_stage_two_out, reset_indicator_out, key_lock_out;
   logic [5:0]  keys_out;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          n_mismatch = 0;
   int          compares = 0;
   pcio_top uut (
      .clock_in, .srst_in, .count_input_a_in, .count_input_b_in, .reset_one_in,
      .reset_two_in, .key_short_in, .tacho_sample_in, .keys_raw_in, .output_stage_one_out,
      .output_stage_two_out, .reset_indicator_out, .key_lock_out, .keys_out, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );
   pcio_field fld (
      .clock_in, .count_a_out(count_input_a_in), .count_b_out(count_input_b_in),
      .reset_one_out(reset_one_in), .reset_two_out(reset_two_in), .key_short_out(key_short_in),
      .load_one_in(output_stage_one_out), .load_two_in(output_stage_two_out)
   );
   always #20 clock_in = ~clock_in;
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic pins(input logic [3:0] e);
      chk({28'h0, key_lock_out, reset_indicator_out, output_stage_two_out,
           output_stage_one_out}, {28'h0, e});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clock_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock_in);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clock_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock_in);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(d, e);
   endtask
   task automatic setup(input pcio_func_t f, input pcio_dir_t d, input logic two,
                        input logic [31:0] s1, input logic [31:0] s2);
      logic [1:0] r;
      wr(REG_CTRL, {23'h0, two, 1'b0, d, 1'b0, f}, r);
      wr(REG_SET1, s1, r);
      wr(REG_SET2, s2, r);
      fld.lines(1'b1, 1'b1, 1'b0);
      cyc(6);
      fld.lines(1'b0, 1'b0, 1'b0);
      cyc(6);
   endtask
   task automatic sample();
      @(posedge clock_in);
      tacho_sample_in <= 1'b1;
      @(posedge clock_in);
      tacho_sample_in <= 1'b0;
      cyc(2);
   endtask
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0]  r;
      rdc(REG_CTRL, CTRL_RESET);
      rd(8'h40, d, r);
      chk({d[29:0], r}, {30'h0, AXI_SLVERR});
      wr(8'h40, 32'h1, r);
      chk({30'h0, r}, {30'h0, AXI_SLVERR});
      wr(REG_PV1, 32'h55, r);
      rdc(REG_PV1, 32'h0);
      wr(REG_SET1, 32'h12345, r);
      rdc(REG_SET1, 32'h12345);
   endtask
   task automatic t_up();
      setup(PCIO_FN_ONE, PCIO_DIR_UP, 1'b0, 32'h3, 32'h9);
      fld.pulse(1'b0, 2);
      pins(4'h0);
      fld.pulse(1'b0, 1);
      rdc(REG_PV1, 32'h3);
      pins(4'h1);
      fld.lines(1'b0, 1'b1, 1'b0);
      fld.pulse(1'b0, 1);
      rdc(REG_PV1, 32'h4);
      pins(4'h1);
      fld.lines(1'b1, 1'b0, 1'b0);
      fld.pulse(1'b0, 2);
      pins(4'h4);
      rdc(REG_PV1, 32'h0);
   endtask
   task automatic t_dirs();
      setup(PCIO_FN_ONE, PCIO_DIR_DOWN, 1'b0, 32'h5, 32'h0);
      rdc(REG_PV1, 32'h5);
      fld.pulse(1'b0, 2);
      rdc(REG_PV1, 32'h3);
      setup(PCIO_FN_TWO, PCIO_DIR_DOWN, 1'b1, 32'h4, 32'h7);
      rdc(REG_PV1, 32'h7);
      setup(PCIO_FN_ONE, PCIO_DIR_IND, 1'b0, 32'h9, 32'h0);
      fld.pulse(1'b0, 3);
      fld.pulse(1'b1, 1);
      rdc(REG_PV1, 32'h2);
      setup(PCIO_FN_ONE, PCIO_DIR_CMD, 1'b0, 32'h9, 32'h0);
      fld.pulse(1'b0, 2);
      rdc(REG_PV1, 32'h2);
      setup(PCIO_FN_ONE, PCIO_DIR_QUAD, 1'b0, 32'h9, 32'h0);
      rdc(REG_PV1, 32'h0);
   endtask
   task automatic t_total_batch();
      setup(PCIO_FN_TOTAL, PCIO_DIR_UP, 1'b0, 32'h9, 32'h9);
      fld.pulse(1'b0, 2);
      rdc(REG_AUX, 32'h2);
      fld.lines(1'b0, 1'b1, 1'b0);
      fld.pulse(1'b0, 1);
      rdc(REG_AUX, 32'h0);
      rdc(REG_PV1, 32'h3);
      pins(4'h0);
      setup(PCIO_FN_BATCH, PCIO_DIR_UP, 1'b1, 32'h1, 32'h2);
      fld.pulse(1'b0, 2);
      pins(4'h3);
      fld.lines(1'b1, 1'b0, 1'b0);
      cyc(6);
      pins(4'h5);
      fld.lines(1'b0, 1'b1, 1'b0);
      cyc(6);
      pins(4'h0);
      rdc(REG_AUX, 32'h0);
   endtask
   task automatic t_dual();
      setup(PCIO_FN_DUAL, PCIO_DIR_DOWN, 1'b0, 32'h9, 32'h9);
      fld.pulse(1'b0, 2);
      fld.pulse(1'b1, 3);
      rdc(REG_PV1, 32'h2);
      rdc(REG_PV2, 32'h3);
      fld.lines(1'b0, 1'b1, 1'b0);
      fld.pulse(1'b1, 1);
      fld.pulse(1'b0, 1);
      rdc(REG_PV2, 32'h0);
      rdc(REG_PV1, 32'h3);
      pins(4'h0);
      fld.lines(1'b1, 1'b0, 1'b0);
      fld.pulse(1'b0, 1);
      fld.pulse(1'b1, 1);
      rdc(REG_PV1, 32'h0);
      rdc(REG_PV2, 32'h1);
      pins(4'h4);
   endtask
   task automatic t_tacho_key();
      logic [1:0] r;
      setup(PCIO_FN_TACHO, PCIO_DIR_UP, 1'b1, 32'h9, 32'h9);
      sample();
      fld.pulse(1'b0, 3);
      fld.pulse(1'b1, 2);
      sample();
      rdc(REG_PV1, 32'h3);
      fld.lines(1'b1, 1'b0, 1'b0);
      fld.pulse(1'b0, 1);
      sample();
      rdc(REG_PV1, 32'h3);
      pins(4'h4);
      setup(PCIO_FN_ONE, PCIO_DIR_UP, 1'b0, 32'h9, 32'h9);
      fld.lines(1'b0, 1'b0, 1'b1);
      keys_raw_in <= 6'h2a;
      cyc(6);
      pins(4'h0);
      wr(REG_CTRL, 32'h1000, r);
      cyc(6);
      pins(4'h8);
      chk({26'h0, keys_out}, 32'h0);
      fld.lines(1'b0, 1'b0, 1'b0);
      cyc(6);
      chk({26'h0, keys_out}, 32'h2a);
   endtask
   initial begin
      cyc(4);
      srst_in <= 1'b0;
      t_regs();
      t_up();
      t_dirs();
      t_total_batch();
      t_dual();
      t_tacho_key();
      summarize();
   end
   initial begin
      #400000;
      n_mismatch++;
      summarize();
   end
endmodule

// ### src/pcio_pkg.sv
// Package with constants, register map and types of the preset counter I/O control.
package pcio_pkg;
   localparam int unsigned CLK_HZ        = 25000000;
   localparam int unsigned CNT_W         = 24;
   localparam int unsigned SYNC_STAGES   = 2;
   // Register byte offsets.
   localparam logic [7:0] REG_CTRL       = 8'h00;
   localparam logic [7:0] REG_SET1       = 8'h04;
   localparam logic [7:0] REG_SET2       = 8'h08;
   localparam logic [7:0] REG_PV1        = 8'h0c;
   localparam logic [7:0] REG_PV2        = 8'h10;
   localparam logic [7:0] REG_AUX        = 8'h14;
   localparam logic [7:0] REG_STAT       = 8'h18;
   localparam logic [7:0] REG_KEYS       = 8'h1c;
   // Control field positions.
   localparam int unsigned CTRL_FUNC_LSB = 0;
   localparam int unsigned CTRL_DIR_LSB  = 4;
   localparam int unsigned CTRL_TWO_BIT  = 8;
   localparam int unsigned CTRL_KPL_LSB  = 12;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
   localparam logic [1:0]  AXI_OKAY      = 2'h0;
   localparam logic [1:0]  AXI_SLVERR    = 2'h2;
   typedef enum logic [2:0] {
      PCIO_FN_ONE, PCIO_FN_TWO, PCIO_FN_TOTAL, PCIO_FN_BATCH, PCIO_FN_DUAL, PCIO_FN_TACHO
   } pcio_func_t;
   typedef enum logic [2:0] {
      PCIO_DIR_UP, PCIO_DIR_DOWN, PCIO_DIR_CMD, PCIO_DIR_IND, PCIO_DIR_QUAD
   } pcio_dir_t;
   typedef enum logic [1:0] {PCIO_W_IDLE, PCIO_W_RESP} pcio_wst_t;
endpackage

// ### src/pcio_sync.sv
// Two-stage synchroniser for the count, reset and key short inputs.
`timescale 1ns/1ps
module pcio_sync
   import pcio_pkg::*;
#(
   parameter int unsigned WIDTH = 5
) (
   // Clock and reset.
   input  wire logic             clock_in,
   input  wire logic             srst_in,
   // Raw pins.
   input  wire logic [WIDTH-1:0] raw_in,
   // Synchronised levels.
   pcio_sync_if.sync_side        sync_out
);
   logic [WIDTH-1:0] stage_one;
   logic [WIDTH-1:0] stage_two;
   logic [WIDTH-1:0] next_stage_one;
   logic [WIDTH-1:0] next_stage_two;
   initial begin
      if (WIDTH != 5) $error("pcio_sync needs WIDTH of 5");
   end
   always_comb begin
      next_stage_one = raw_in;
      next_stage_two = stage_one;
   end
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         stage_one <= '0;
         stage_two <= '0;
      end else begin
         stage_one <= next_stage_one;
         stage_two <= next_stage_two;
      end
   end
   assign sync_out.count_a   = stage_two[0];
   assign sync_out.count_b   = stage_two[1];
   assign sync_out.reset_one = stage_two[2];
   assign sync_out.reset_two = stage_two[3];
   assign sync_out.key_short = stage_two[4];
endmodule

// ### src/pcio_sync_if.sv
// Interface carrying the synchronised external inputs.
`timescale 1ns/1ps
interface pcio_sync_if;
   logic count_a;
   logic count_b;
   logic reset_one;
   logic reset_two;
   logic key_short;
   modport sync_side (output count_a, output count_b, output reset_one,
                      output reset_two, output key_short);
   modport core_side (input count_a, input count_b, input reset_one,
                      input reset_two, input key_short);
endinterface

// ### src/pcio_top.sv
// Preset counter input and output control with an AXI4-Lite register slave.
//
// Function
// - Count pulses outside dual and tachometer modes, all directions
// - Dual mode: two separate increment-only values
// - Primary reset resets value and clears outputs outside dual and tachometer modes; batch keeps output one
// - No counting during or while primary reset, except dual second value and total
// - Reset indicator follows primary reset input
// - Reset value zero, or set value downcount
// - Dual: primary reset zeroes first value
// - Secondary reset never lights reset indicator
// - Preset functions ignore secondary reset
// - Total reset clears and holds total
// - Batch: secondary reset clears batch count
// - Dual: secondary reset clears second value
// - Outputs activate when set value reached; in down direction output two activates at zero
// - Tachometer: primary reset freezes value, outputs
// - Tachometer uses first count input only
// - Key short blocks front-panel keys
`timescale 1ns/1ps
module pcio_top
   import pcio_pkg::*;
#(
   parameter int unsigned WIDTH = CNT_W
) (
   // Clock and reset.
   input  wire logic        clock_in,
   input  wire logic        srst_in,
   // External pins.
   input  wire logic        count_input_a_in,
   input  wire logic        count_input_b_in,
   input  wire logic        reset_one_in,
   input  wire logic        reset_two_in,
   input  wire logic        key_short_in,
   input  wire logic        tacho_sample_in,
   input  wire logic [5:0]  keys_raw_in,
   output logic             output_stage_one_out,
   output logic             output_stage_two_out,
   output logic             reset_indicator_out,
   output logic             key_lock_out,
   output logic [5:0]       keys_out,
   // AXI4-Lite slave.
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   pcio_sync_if sync_bus ();
   logic [WIDTH-1:0] pv1, pv2, aux, set1, set2, tacho_acc;
   logic [WIDTH-1:0] next_pv1, next_pv2, next_aux, next_set1, next_set2, next_tacho_acc;
   logic [31:0]      ctrl, next_ctrl;
   logic             output_stage_one, output_stage_two, next_output_stage_one, next_output_stage_two;
   logic             prev_a, prev_b;
   logic             reset_ind, next_reset_ind, key_lock, next_key_lock;
   logic [5:0]       keys, next_keys;
   logic             aw_held, w_held, next_aw_held, next_w_held;
   logic [7:0]       aw_addr, next_aw_addr;
   logic [31:0]      w_data, next_w_data;
   logic [3:0]       w_strb, next_w_strb;
   logic             bvalid, next_bvalid, rvalid, next_rvalid;
   logic [1:0]       bresp, next_bresp, rresp, next_rresp;
   logic [31:0]      rdata, next_rdata;
   pcio_func_t       func;
   pcio_dir_t        dir;
   logic             two_stage;
   logic [1:0]       kpl;
   logic             rise_a, rise_b, fall_a, up_step, dn_step;
   logic             do_write;
   initial begin
      if (WIDTH < 2 || WIDTH > 32) $error("pcio_top WIDTH must be 2 to 32");
   end
   pcio_sync #(
      .WIDTH (5)
   ) u_sync (
      .clock_in (clock_in),
      .srst_in  (srst_in),
      .raw_in   ({key_short_in, reset_two_in, reset_one_in, count_input_b_in,
                  count_input_a_in}),
      .sync_out (sync_bus)
   );
   assign func      = pcio_func_t'(ctrl[CTRL_FUNC_LSB +: 3]);
   assign dir       = pcio_dir_t'(ctrl[CTRL_DIR_LSB +: 3]);
   assign two_stage = ctrl[CTRL_TWO_BIT];
   assign kpl       = ctrl[CTRL_KPL_LSB +: 2];
   assign rise_a    = sync_bus.count_a & ~prev_a;
   assign fall_a    = ~sync_bus.count_a & prev_a;
   assign rise_b    = sync_bus.count_b & ~prev_b;
   // Direction decode of the count inputs.
   always_comb begin
      up_step = 1'b0;
      dn_step = 1'b0;
      unique case (dir)
         PCIO_DIR_UP: begin
            up_step = rise_a;
         end
         PCIO_DIR_DOWN: begin
            dn_step = rise_a;
         end
         PCIO_DIR_CMD: begin
            up_step = rise_a & ~sync_bus.count_b;
            dn_step = rise_a & sync_bus.count_b;
         end
         PCIO_DIR_IND: begin
            up_step = rise_a & ~rise_b;
            dn_step = rise_b & ~rise_a;
         end
         PCIO_DIR_QUAD: begin
            up_step = rise_a & ~sync_bus.count_b;
            dn_step = fall_a & ~sync_bus.count_b;
         end
         default: begin
            up_step = 1'b0;
         end
      endcase
   end
   // Counting, resets and output comparison.
   always_comb begin
      next_pv1       = pv1;
      next_pv2       = pv2;
      next_aux       = aux;
      next_output_stage_one      = output_stage_one;
      next_output_stage_two      = output_stage_two;
      next_tacho_acc = tacho_acc;
      next_reset_ind = sync_bus.reset_one;
      next_key_lock  = sync_bus.key_short & (kpl != 2'h0);
      next_keys      = next_key_lock ? 6'h00 : keys_raw_in;
      unique case (func)
         PCIO_FN_DUAL: begin
            if (sync_bus.reset_one) begin
               next_pv1 = '0;
            end else if (rise_a) begin
               next_pv1 = pv1 + 1'b1;
            end
            if (sync_bus.reset_two) begin
               next_pv2 = '0;
            end else if (rise_b) begin
               next_pv2 = pv2 + 1'b1;
            end
            next_output_stage_one = (pv1 >= set1);
            next_output_stage_two = (pv2 >= set2);
         end
         PCIO_FN_TACHO: begin
            if (!sync_bus.reset_one) begin
               if (tacho_sample_in) begin
                  next_pv1       = tacho_acc;
                  next_tacho_acc = {{(WIDTH-1){1'b0}}, rise_a};
               end else if (rise_a) begin
                  next_tacho_acc = tacho_acc + 1'b1;
               end
               next_output_stage_one = (pv1 >= set1);
               next_output_stage_two = (pv1 >= set2);
            end
         end
         default: begin
            if (sync_bus.reset_one) begin
               next_pv1  = (dir == PCIO_DIR_DOWN) ? (two_stage ? set2 : set1) : '0;
               next_output_stage_two = 1'b0;
               if (func != PCIO_FN_BATCH) begin
                  next_output_stage_one = 1'b0;
               end
            end else begin
               if (up_step) begin
                  next_pv1 = pv1 + 1'b1;
               end else if (dn_step) begin
                  next_pv1 = pv1 - 1'b1;
               end
               next_output_stage_two = (dir == PCIO_DIR_DOWN) ? (pv1 == '0) : (pv1 >= set2);
               if (func != PCIO_FN_BATCH) begin
                  next_output_stage_one = (pv1 >= set1);
               end else if (next_output_stage_two && !output_stage_two) begin
                  next_aux = aux + 1'b1;
               end
            end
            if (func == PCIO_FN_TOTAL) begin
               if (sync_bus.reset_two) begin
                  next_aux = '0;
               end else if (up_step || dn_step) begin
                  next_aux = aux + 1'b1;
               end
            end
            if (func == PCIO_FN_BATCH) begin
               if (sync_bus.reset_two) begin
                  next_aux  = '0;
                  next_output_stage_one = 1'b0;
               end else if (aux >= set1) begin
                  next_output_stage_one = 1'b1;
               end
            end
         end
      endcase
   end
   // AXI4-Lite slave.
   assign do_write = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !bvalid;
   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = bvalid && !s_axi_bready;
      next_bresp   = bresp;
      next_rvalid  = rvalid && !s_axi_rready;
      next_rresp   = rresp;
      next_rdata   = rdata;
      next_ctrl    = ctrl;
      next_set1    = set1;
      next_set2    = set2;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = AXI_OKAY;
         unique case (next_aw_addr)
            REG_CTRL: begin
               for (int i = 0; i < 4; i++) begin
                  if (next_w_strb[i]) next_ctrl[i*8 +: 8] = next_w_data[i*8 +: 8];
               end
            end
            REG_SET1: begin
               next_set1 = next_w_data[WIDTH-1:0];
            end
            REG_SET2: begin
               next_set2 = next_w_data[WIDTH-1:0];
            end
            default: begin
               next_bresp = AXI_SLVERR;
            end
         endcase
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = AXI_OKAY;
         next_rdata  = 32'h0000_0000;
         unique case (s_axi_araddr)
            REG_CTRL: next_rdata = ctrl;
            REG_SET1: next_rdata[WIDTH-1:0] = set1;
            REG_SET2: next_rdata[WIDTH-1:0] = set2;
            REG_PV1:  next_rdata[WIDTH-1:0] = pv1;
            REG_PV2:  next_rdata[WIDTH-1:0] = pv2;
            REG_AUX:  next_rdata[WIDTH-1:0] = aux;
            REG_STAT: next_rdata[3:0] = {key_lock, reset_ind, output_stage_two, output_stage_one};
            REG_KEYS: next_rdata[5:0] = keys;
            default:  next_rresp = AXI_SLVERR;
         endcase
      end
   end
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         pv1 <= '0;
         pv2 <= '0;
         aux <= '0;
         tacho_acc <= '0;
         output_stage_one <= 1'b0;
         output_stage_two <= 1'b0;
         prev_a <= 1'b0;
         prev_b <= 1'b0;
         reset_ind <= 1'b0;
         key_lock <= 1'b0;
         keys <= 6'h00;
         ctrl <= CTRL_RESET;
         set1 <= '0;
         set2 <= '0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= AXI_OKAY;
         rvalid <= 1'b0;
         rresp <= AXI_OKAY;
         rdata <= 32'h0000_0000;
      end else begin
         pv1 <= next_pv1;
         pv2 <= next_pv2;
         aux <= next_aux;
         tacho_acc <= next_tacho_acc;
         output_stage_one <= next_output_stage_one;
         output_stage_two <= next_output_stage_two;
         prev_a <= sync_bus.count_a;
         prev_b <= sync_bus.count_b;
         reset_ind <= next_reset_ind;
         key_lock <= next_key_lock;
         keys <= next_keys;
         ctrl <= next_ctrl;
         set1 <= next_set1;
         set2 <= next_set2;
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
      end
   end
   // Ready flags are registers so every output comes from a flip-flop.
   logic awready_q, wready_q, arready_q;
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         arready_q <= 1'b0;
      end else begin
         awready_q <= !next_aw_held && !next_bvalid && !(awready_q && s_axi_awvalid);
         wready_q  <= !next_w_held && !next_bvalid && !(wready_q && s_axi_wvalid);
         arready_q <= !next_rvalid && !(arready_q && s_axi_arvalid);
      end
   end
   assign s_axi_awready        = awready_q;
   assign s_axi_wready         = wready_q;
   assign s_axi_arready        = arready_q;
   assign s_axi_bvalid         = bvalid;
   assign s_axi_bresp          = bresp;
   assign s_axi_rvalid         = rvalid;
   assign s_axi_rresp          = rresp;
   assign s_axi_rdata          = rdata;
   assign output_stage_one_out = output_stage_one;
   assign output_stage_two_out = output_stage_two;
   assign reset_indicator_out  = reset_ind;
   assign key_lock_out         = key_lock;
   assign keys_out             = keys;
endmodule
